// file: core/fas_host.sv
/*
 Host controller that runs autoselect queries on a parallel NOR flash.
 Assumes the flash pins are sampled here through two flops and the high-voltage driver obeys hv_a9.
*/
`timescale 1ns/1ps
module fas_host (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic req_valid_in,
   input wire fas_pkg::fas_req_t req_in,
   output logic req_ready_out,
   output logic rsp_valid_out,
   output fas_pkg::fas_rsp_t rsp_out,
   output logic [3:0] top_sector_out,
   output logic otp_cust_out,
   input wire logic [fas_pkg::DATA_W-1:0] dq_in,
   output fas_pkg::fas_pins_t pins_out
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef enum logic [3:0] {
      S_IDLE, S_HV_SETUP, S_WR, S_WR_GAP, S_RD, S_RD_GAP, S_DONE
   } fas_state_t;

   typedef struct packed {
      fas_state_t st;
      fas_pkg::fas_req_t req;
      logic [1:0] wr_idx;
      logic [1:0] rd_idx;
      logic [3:0] cnt;
      fas_pkg::fas_pins_t pins;
      fas_pkg::fas_rsp_t rsp;
      logic rsp_valid;
      logic ready;
      logic [3:0] top_sect;
      logic otp_cust;
   } fas_host_state_t;

   fas_host_state_t s_q, s_d;
   logic [fas_pkg::DATA_W-1:0] dq_meta_q, dq_sync_q;

   always_ff @(posedge clk_in) begin
      dq_meta_q <= dq_in;
      dq_sync_q <= dq_meta_q;
   end

   function automatic logic [1:0] rd_count(input fas_pkg::fas_op_t op);
      return (op == fas_pkg::FAS_OP_PART) ? 2'd3 : 2'd1;
   endfunction

   // Low address of read number i for an operation
   function automatic logic [7:0] rd_addr(input fas_pkg::fas_op_t op, input logic [1:0] i);
      case (op)
         fas_pkg::FAS_OP_MAKER: return fas_pkg::ADR_MAKER;
         fas_pkg::FAS_OP_PART: begin
            if (i == 2'd0) return fas_pkg::ADR_PART1;
            if (i == 2'd1) return fas_pkg::ADR_PART2;
            return fas_pkg::ADR_PART3;
         end
         fas_pkg::FAS_OP_PROT: return fas_pkg::ADR_PROT;
         default: return fas_pkg::ADR_LOCK;
      endcase
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic [fas_pkg::ADDR_W-1:0] a;
      a = '0;
      s_d = s_q;
      s_d.rsp_valid = 1'b0;
      case (s_q.st)
         S_IDLE: begin
            s_d.ready = 1'b1;
            s_d.pins.hv_a9 = 1'b0;
            if (req_valid_in && s_q.ready) begin
               s_d.req = req_in;
               s_d.ready = 1'b0;
               s_d.wr_idx = (req_in.op == fas_pkg::FAS_OP_EXIT) ? 2'd2 : 2'd0;
               s_d.rd_idx = 2'd0;
               s_d.rsp = '0;
               s_d.top_sect = fas_pkg::top_sector(req_in.sect_addr);
               s_d.otp_cust = (req_in.sect_addr >= fas_pkg::OTP_CUST_LO) &&
                  (req_in.sect_addr <= fas_pkg::OTP_CUST_HI);
               s_d.cnt = 4'(fas_pkg::SETUP_CYC);
               if (req_in.use_hv && req_in.op != fas_pkg::FAS_OP_EXIT) begin
                  s_d.pins.hv_a9 = 1'b1;
                  s_d.st = S_HV_SETUP;
               end else begin
                  s_d.st = S_WR;
               end
            end
         end
         S_HV_SETUP: begin
            if (s_q.cnt == 4'h0) s_d.st = S_RD;
            else s_d.cnt = s_q.cnt - 4'h1;
         end
         S_WR: begin
            a = '0;
            case (s_q.wr_idx)
               2'd0: begin a[11:0] = fas_pkg::CMD_ADR1; s_d.pins.dq = fas_pkg::CMD_DAT1; end
               2'd1: begin a[11:0] = fas_pkg::CMD_ADR2; s_d.pins.dq = fas_pkg::CMD_DAT2; end
               default: begin
                  a[11:0] = fas_pkg::CMD_ADR1;
                  s_d.pins.dq = (s_q.req.op == fas_pkg::FAS_OP_EXIT) ? fas_pkg::CMD_EXIT : fas_pkg::CMD_DAT3;
                  if (s_q.req.bank_sel)
                     a[fas_pkg::BANK_LSB +: 3] = s_q.req.bank;
               end
            endcase
            s_d.pins.addr = a;
            s_d.pins.ce_n = 1'b0;
            s_d.pins.we_n = 1'b0;
            s_d.pins.dq_oe = 1'b1;
            s_d.st = S_WR_GAP;
         end
         S_WR_GAP: begin
            s_d.pins.we_n = 1'b1;
            s_d.pins.ce_n = 1'b1;
            s_d.pins.dq_oe = 1'b0;
            if (s_q.req.op == fas_pkg::FAS_OP_EXIT) begin
               s_d.st = S_DONE;
            end else if (s_q.wr_idx == 2'd2) begin
               s_d.st = S_RD;
            end else begin
               s_d.wr_idx = s_q.wr_idx + 2'd1;
               s_d.st = S_WR;
            end
         end
         S_RD: begin
            a = '0;
            a[7:0] = rd_addr(s_q.req.op, s_q.rd_idx);
            if (s_q.req.op == fas_pkg::FAS_OP_PROT)
               a[fas_pkg::ADDR_W-1:fas_pkg::SMALL_SECT_SHIFT] =
                  s_q.req.sect_addr[fas_pkg::ADDR_W-1:fas_pkg::SMALL_SECT_SHIFT];
            else if (s_q.req.bank_sel && !s_q.req.use_hv)
               a[fas_pkg::BANK_LSB +: 3] = s_q.req.bank;
            s_d.pins.addr = a;
            s_d.pins.ce_n = 1'b0;
            s_d.pins.oe_n = 1'b0;
            s_d.pins.dq_oe = 1'b0;
            // Wait access plus two sync flops before sampling
            if (s_q.pins.oe_n) begin
               s_d.cnt = 4'(fas_pkg::ACCESS_CYC + 2);
            end else if (s_q.cnt != 4'h0) begin
               s_d.cnt = s_q.cnt - 4'h1;
            end else begin
               case (s_q.req.op)
                  fas_pkg::FAS_OP_PART: begin
                     if (s_q.rd_idx == 2'd0) s_d.rsp.code0 = dq_sync_q;
                     else if (s_q.rd_idx == 2'd1) s_d.rsp.code1 = dq_sync_q;
                     else s_d.rsp.code2 = dq_sync_q;
                  end
                  fas_pkg::FAS_OP_PROT: begin
                     s_d.rsp.code0 = dq_sync_q;
                     s_d.rsp.prot = dq_sync_q[fas_pkg::PROT_BIT];
                  end
                  fas_pkg::FAS_OP_LOCK: begin
                     s_d.rsp.code0 = dq_sync_q;
                     s_d.rsp.fact_lock = dq_sync_q[fas_pkg::LOCK_FACT_BIT];
                     s_d.rsp.cust_lock = dq_sync_q[fas_pkg::LOCK_FACT_BIT] & dq_sync_q[fas_pkg::LOCK_CUST_BIT];
                  end
                  default: s_d.rsp.code0 = {8'h00, dq_sync_q[7:0]};
               endcase
               s_d.pins.oe_n = 1'b1;
               s_d.pins.ce_n = 1'b1;
               s_d.st = S_RD_GAP;
            end
         end
         S_RD_GAP: begin
            if (s_q.rd_idx + 2'd1 >= rd_count(s_q.req.op)) begin
               s_d.st = S_DONE;
            end else begin
               s_d.rd_idx = s_q.rd_idx + 2'd1;
               s_d.st = S_RD;
            end
         end
         S_DONE: begin
            s_d.pins.hv_a9 = 1'b0;
            s_d.rsp_valid = 1'b1;
            s_d.st = S_IDLE;
         end
         default: s_d.st = S_IDLE;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_q <= '0;
         s_q.st <= S_IDLE;
         s_q.pins.ce_n <= 1'b1;
         s_q.pins.oe_n <= 1'b1;
         s_q.pins.we_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign req_ready_out = s_q.ready;
   assign rsp_valid_out = s_q.rsp_valid;
   assign rsp_out = s_q.rsp;
   assign top_sector_out = s_q.top_sect;
   assign otp_cust_out = s_q.otp_cust;
   assign pins_out = s_q.pins;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_hv_during_read: assert property (@(posedge clk_in) disable iff (rst_in)
      (s_q.st == S_RD && s_q.req.use_hv && s_q.req.op != fas_pkg::FAS_OP_EXIT) |-> pins_out.hv_a9)
      else $error("high voltage missing in read");
   a_no_drive_read: assert property (@(posedge clk_in) disable iff (rst_in)
      !pins_out.oe_n |-> !pins_out.dq_oe)
      else $error("bus driven while flash outputs");
   a_oe_hold_access: assert property (@(posedge clk_in) disable iff (rst_in)
      $fell(pins_out.oe_n) |-> !pins_out.oe_n [*4])
      else $error("read shorter than access time");
   a_write_pulse_one: assert property (@(posedge clk_in) disable iff (rst_in)
      $fell(pins_out.we_n) |=> pins_out.we_n)
      else $error("write pulse not one cycle");
   a_prot_sect_addr: assert property (@(posedge clk_in) disable iff (rst_in)
      (!pins_out.oe_n && s_q.req.op == fas_pkg::FAS_OP_PROT) |->
      pins_out.addr[22:12] == s_q.req.sect_addr[22:12])
      else $error("sector address wrong");
   a_prot_bit_map: assert property (@(posedge clk_in) disable iff (rst_in)
      (rsp_valid_out && s_q.req.op == fas_pkg::FAS_OP_PROT) |-> rsp_out.prot == rsp_out.code0[0])
      else $error("protect bit wrong");
   a_lock_bits_map: assert property (@(posedge clk_in) disable iff (rst_in)
      (rsp_valid_out && s_q.req.op == fas_pkg::FAS_OP_LOCK) |-> (!rsp_out.cust_lock || rsp_out.fact_lock))
      else $error("customer lock without factory");
   a_top_sect_dec: assert property (@(posedge clk_in) disable iff (rst_in)
      (s_q.st != S_IDLE && s_q.req.sect_addr >= fas_pkg::TOP_SECT_BASE) |-> top_sector_out == 4'h7)
      else $error("top sector decode wrong");
   a_otp_cust_dec: assert property (@(posedge clk_in) disable iff (rst_in)
      (s_q.st != S_IDLE && s_q.req.sect_addr <= fas_pkg::OTP_FACT_HI) |-> !otp_cust_out)
      else $error("factory words flagged customer");
   a_rsp_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
      rsp_valid_out |=> !rsp_valid_out && req_ready_out)
      else $error("response not one pulse");
endmodule // fas_host

// file: core/fas_pkg.sv
/*
 Package for the host-side autoselect query controller of a 16-bit parallel NOR flash.
 Assumes one 40 MHz clock, a synchronous active-high reset, and a flash wired to the pins.
*/
package fas_pkg;
   localparam int ADDR_W = 23;
   localparam int DATA_W = 16;
   // Timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int ACCESS_NS = 70;
   localparam int SETUP_NS = 50;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Low address patterns of the query reads
   localparam logic [7:0] ADR_MAKER = 8'h00;
   localparam logic [7:0] ADR_PART1 = 8'h01;
   localparam logic [7:0] ADR_PART2 = 8'h0E;
   localparam logic [7:0] ADR_PART3 = 8'h0F;
   localparam logic [7:0] ADR_PROT = 8'h02;
   localparam logic [7:0] ADR_LOCK = 8'h03;
   // Command sequence
   localparam logic [11:0] CMD_ADR1 = 12'h555;
   localparam logic [11:0] CMD_ADR2 = 12'h2AA;
   localparam logic [15:0] CMD_DAT1 = 16'h00AA;
   localparam logic [15:0] CMD_DAT2 = 16'h0055;
   localparam logic [15:0] CMD_DAT3 = 16'h0090;
   localparam logic [15:0] CMD_EXIT = 16'h00F0;
   // Answer fields
   localparam int PROT_BIT = 0;
   localparam int LOCK_FACT_BIT = 7;
   localparam int LOCK_CUST_BIT = 6;
   // Secured region and sector map
   localparam logic [ADDR_W-1:0] OTP_FACT_LO = 23'h000000;
   localparam logic [ADDR_W-1:0] OTP_FACT_HI = 23'h00003F;
   localparam logic [ADDR_W-1:0] OTP_CUST_LO = 23'h000040;
   localparam logic [ADDR_W-1:0] OTP_CUST_HI = 23'h00007F;
   localparam logic [7:0] TOP_SMALL_PFX = 8'hFF;
   localparam logic [ADDR_W-1:0] TOP_SECT_BASE = 23'h7FF000;
   localparam int SMALL_SECT_SHIFT = 12;
   localparam int BIG_SECT_SHIFT = 15;
   localparam int BANK_LSB = 20;

   typedef enum logic [2:0] {
      FAS_OP_MAKER,
      FAS_OP_PART,
      FAS_OP_PROT,
      FAS_OP_LOCK,
      FAS_OP_EXIT
   } fas_op_t;

   typedef struct packed {
      fas_op_t op;
      logic use_hv;
      logic bank_sel;
      logic [2:0] bank;
      logic [ADDR_W-1:0] sect_addr;
   } fas_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] code0;
      logic [DATA_W-1:0] code1;
      logic [DATA_W-1:0] code2;
      logic prot;
      logic fact_lock;
      logic cust_lock;
   } fas_rsp_t;

   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic hv_a9;
      logic dq_oe;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq;
   } fas_pins_t;

   // Sector index of a 4-Kword sector in the top 32-Kword group, or 8 for a large sector
   function automatic logic [3:0] top_sector(input logic [ADDR_W-1:0] a);
      if (a[ADDR_W-1 -: 8] == TOP_SMALL_PFX)
         return {1'b0, a[SMALL_SECT_SHIFT +: 3]};
      return 4'h8;
   endfunction
endpackage

// file: verif/fas_flash_model.sv
/*
 Behavioural flash answering autoselect reads and command writes.
 Assumes the host pin struct of the package; lock state comes from the bench.
*/
`timescale 1ns/1ps
module fas_flash_model #(
   parameter logic [15:0] MAKER_ID = 16'h005A, // Arbitrary value
   parameter logic [47:0] PART_ID = 48'h1234_5678_9ABC // Arbitrary value
) (
   input wire fas_pkg::fas_pins_t pins_in,
   input wire logic cust_locked_in,
   output logic [15:0] dq_out
);
   int step = 0;
   logic as_cmd = 1'b0;
   logic [2:0] bank_q = 3'h0;
   logic [15:0] rd_val;
   logic rd_en, as_on, prot;
   // -----------------
   // Command writes
   // -----------------
   always @(negedge pins_in.we_n) begin
      if (pins_in.ce_n === 1'b0) begin
         if (pins_in.dq == fas_pkg::CMD_EXIT) begin
            as_cmd = 1'b0;
            step = 0;
         end else if (step == 2 && pins_in.dq == fas_pkg::CMD_DAT3) begin
            as_cmd = 1'b1;
            bank_q = pins_in.addr[22:20];
            step = 0;
         end else if (step == 1 && pins_in.dq == fas_pkg::CMD_DAT2) begin
            step = 2;
         end else begin
            step = (pins_in.dq == fas_pkg::CMD_DAT1) ? 1 : 0;
         end
      end
   end
   // -----------------
   // Read answers
   // -----------------
   always_comb begin
      rd_en = !pins_in.ce_n && !pins_in.oe_n && pins_in.we_n;
      as_on = pins_in.hv_a9 || (as_cmd && (bank_q == 3'h0 || pins_in.addr[22:20] == bank_q));
      prot = (pins_in.addr[22:15] == 8'hFF) ? pins_in.addr[12] : pins_in.addr[15];
      rd_val = {5'h15, pins_in.addr[22:12]};
      if (as_on) begin
         case (pins_in.addr[7:0])
            fas_pkg::ADR_MAKER: rd_val = MAKER_ID;
            fas_pkg::ADR_PART1: rd_val = PART_ID[47:32];
            fas_pkg::ADR_PART2: rd_val = PART_ID[31:16];
            fas_pkg::ADR_PART3: rd_val = PART_ID[15:0];
            fas_pkg::ADR_PROT: rd_val = {15'h0, prot};
            fas_pkg::ADR_LOCK: rd_val = {8'h0, 1'b1, cust_locked_in, 6'h0};
            default: rd_val = 16'h0;
         endcase
      end
   end
   // Released bus shows the inverse, never the last value
   assign #(fas_pkg::ACCESS_NS) dq_out = rd_en ? rd_val : ~rd_val;
endmodule // fas_flash_model

// file: verif/tb_fas_host.sv
/*
 Self-checking bench for the autoselect host controller.
 Assumes the behavioural flash model on the far side of the pins.
*/
`timescale 1ns/1ps
module tb_fas_host;
   localparam logic [15:0] MAKER = 16'h005A; // Arbitrary value
   localparam logic [47:0] PART = 48'h1234_5678_9ABC; // Arbitrary value
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic req_valid_in = 1'b0;
   logic cust_lk = 1'b1;
   fas_pkg::fas_req_t req_in = '0;
   logic req_ready_out, rsp_valid_out, otp_cust_out;
   fas_pkg::fas_rsp_t rsp_out;
   logic [3:0] top_sector_out;
   logic [15:0] dq_in;
   fas_pkg::fas_pins_t pins_out;
   int error_cnt = 0;
   int compares = 0;
   logic busy = 1'b0;
   logic exp_hv = 1'b0;
   logic [22:0] sa_tab [4] = '{23'h7FF000, 23'h7F8000, 23'h7E8000, 23'h7F0000};
   logic [3:0] sect_tab [4] = '{4'h7, 4'h0, 4'h8, 4'h8};
   logic [22:0] otp_tab [4] = '{23'h00003F, 23'h000040, 23'h00007F, 23'h000080};
   logic otp_exp [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

   always #12.5 clk_in = ~clk_in;

   fas_host fas_host_inst (.clk_in(clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in), .req_in(req_in),
      .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out), .rsp_out(rsp_out),
      .top_sector_out(top_sector_out), .otp_cust_out(otp_cust_out), .dq_in(dq_in), .pins_out(pins_out));
   fas_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) fas_flash_model_inst (.pins_in(pins_out),
      .cust_locked_in(cust_lk), .dq_out(dq_in));

   // -----------------
   // Tasks
   // -----------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic run(input fas_pkg::fas_op_t op, input logic hv, input logic bsel, input logic [2:0] bank,
      input logic [22:0] sa);
      int n;
      req_in = '{op: op, use_hv: hv, bank_sel: bsel, bank: bank, sect_addr: sa};
      req_valid_in = 1'b1;
      exp_hv = hv;
      busy = 1'b1;
      n = 0;
      while (req_ready_out !== 1'b1 && n < 50) begin
         @(posedge clk_in);
         #2 n++;
      end
      @(posedge clk_in);
      #2 req_valid_in = 1'b0;
      n = (n >= 50) ? 300 : 0;
      while (rsp_valid_out !== 1'b1 && n < 300) begin
         @(posedge clk_in);
         #2 n++;
      end
      busy = 1'b0;
      if (rsp_valid_out !== 1'b1) begin
         error_cnt++;
         print_verdict();
      end
   endtask

   // Reads must see the identification voltage only on the voltage method
   always @(posedge clk_in) begin
      if (busy && pins_out.oe_n === 1'b0 && pins_out.hv_a9 !== exp_hv) begin
         error_cnt++;
         $display("mismatch %0t identification voltage during read", $time);
      end
   end

   // -----------------
   // Scenarios
   // -----------------
   initial begin
      repeat (10) @(posedge clk_in);
      #2 rst_in = 1'b0;
      repeat (2) @(posedge clk_in);
      #2 check({pins_out.ce_n, pins_out.oe_n, pins_out.we_n, pins_out.hv_a9, pins_out.dq_oe, req_ready_out}, 16'h39);
      run(fas_pkg::FAS_OP_MAKER, 1'b1, 1'b0, 3'h0, 23'h0);
      check(rsp_out.code0, MAKER);
      @(posedge clk_in);
      #2 check(pins_out.hv_a9, 1'b0);
      for (int m = 0; m < 2; m++) begin
         run(fas_pkg::FAS_OP_PART, m[0], 1'b0, 3'h0, 23'h0);
         check(rsp_out.code0, PART[47:32]);
         check(rsp_out.code1, PART[31:16]);
         check(rsp_out.code2, PART[15:0]);
      end
      run(fas_pkg::FAS_OP_EXIT, 1'b0, 1'b0, 3'h0, 23'h0);
      for (int i = 0; i < 4; i++) begin
         run(fas_pkg::FAS_OP_PROT, !i[0], 1'b0, 3'h0, sa_tab[i]);
         check(rsp_out.code0, {15'h0, !i[0]});
         check(rsp_out.prot, !i[0]);
         check(top_sector_out, sect_tab[i]);
      end
      for (int i = 0; i < 4; i++) begin
         cust_lk = i[0];
         run(fas_pkg::FAS_OP_LOCK, i[1], 1'b0, 3'h0, otp_tab[i]);
         check(rsp_out.code0, {8'h0, 1'b1, i[0], 6'h0});
         check({rsp_out.fact_lock, rsp_out.cust_lock}, {1'b1, i[0]});
         check(otp_cust_out, otp_exp[i]);
      end
      run(fas_pkg::FAS_OP_PROT, 1'b0, 1'b1, 3'h7, 23'h7FF000);
      check(rsp_out.code0, 16'h0001);
      run(fas_pkg::FAS_OP_MAKER, 1'b0, 1'b1, 3'h3, 23'h0);
      check(rsp_out.code0, MAKER);
      run(fas_pkg::FAS_OP_EXIT, 1'b0, 1'b0, 3'h0, 23'h0);
      print_verdict();
   end
endmodule // tb_fas_host
